/* File: design/gpc_regs.vh */
// Register map, field positions and reset values of the pin control pair
`ifndef GPC_REGS_VH
`define GPC_REGS_VH
`define GPC_ADDR_W        8
`define GPC_OFF_PIN2      8'h14
`define GPC_OFF_PIN3      8'h18
`define GPC_OFF_IRQ_STAT  8'h40
`define GPC_OFF_IRQ_MASK  8'h44
`define GPC_OFF_PIN_LEVEL 8'h48
`define GPC_B_FWD_MASK    25
`define GPC_B_TRIG_HI     23
`define GPC_B_TRIG_LO     21
`define GPC_B_PEND_EN     20
`define GPC_B_DRV_HI      14
`define GPC_B_DRV_LO      12
`define GPC_B_PU_STRONG   11
`define GPC_B_PD_WEAK     9
`define GPC_B_PU_ALT      8
`define GPC_B_IN_EN       7
`define GPC_B_OUT_EN      6
`define GPC_B_HYST        5
`define GPC_B_ANALOG      4
`define GPC_B_FSEL_HI     3
`define GPC_B_FSEL_LO     0
`define GPC_WMASK_PIN2    32'h02F0_7BE0
`define GPC_WMASK_PIN3    32'h02F0_7BFF
`define GPC_FSEL_MASK2    32'h0000_0007
`define GPC_RST_PIN2      32'h0000_1000
`define GPC_RST_PIN3      32'h0000_1001
`define GPC_TRIG_RISE     3'h0
`define GPC_TRIG_FALL     3'h1
`define GPC_TRIG_BOTH     3'h2
`define GPC_TRIG_HIGH     3'h3
`define GPC_TRIG_LOW      3'h4
`endif

/* File: design/gpc_trigger_detect.v */
// Synchroniser and trigger detector for one pin
`timescale 1ns/1ps
module gpc_trigger_detect (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst_n,
	// Pin and mode
	input  wire       pinIn,
	input  wire [2:0] trigSel,
	// Results
	output reg        pinLevel,
	output reg        trigHit
);
`include "gpc_regs.vh"
	reg syncA_q;
	reg syncB_q;
	reg prev_q;
	// Two-stage synchroniser, then history for edges
	always @(posedge core_clk) begin
		if (!rst_n) begin
			syncA_q <= 1'b0;
			syncB_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			syncA_q <= pinIn;
			syncB_q <= syncA_q;
			prev_q  <= syncB_q;
		end
	end
	// Decode of trigger mode
	always @* begin
		pinLevel = syncB_q;
		case (trigSel)
			`GPC_TRIG_RISE: trigHit = syncB_q & ~prev_q;
			`GPC_TRIG_FALL: trigHit = ~syncB_q & prev_q;
			`GPC_TRIG_BOTH: trigHit = syncB_q ^ prev_q;
			`GPC_TRIG_HIGH: trigHit = syncB_q;
			`GPC_TRIG_LOW:  trigHit = ~syncB_q;
			default:        trigHit = 1'b0;
		endcase
	end
endmodule // gpc_trigger_detect

/* File: design/gpc_pin_pair.v */
// Control registers, pad controls and trigger interrupts for pins two and three
//
// Overview of operation
// - Trigger codes 000, 001, 010 detect rising, falling and either edge.
// - Code 011 detects high level, 100 low level; other codes detect nothing.
// - Pending enable set: trigger sets pending; forwarded only with forward mask.
// - Pending enable clear: no pending set and no request forwarded.
// - Forward mask bit 25 blocks the request when zero, passes when one.
// - Drive strength bits 14:12 choose eight drive levels; reset code 1.
// - Bit 11 connects the strong pull-up; reset zero.
// - Bit 9 connects the weak pull-down; reset zero.
// - Pin two bit 8 connects the mid pull-up; reset zero.
// - Pin three bit 8 connects the weak pull-up; reset zero.
// - Bit 7 enables the input buffer so the level reaches the core; on pin three only while bit 4 is clear.
// - Bit 6 enables the output driver, on pin three only while bit 4 is clear; reset zero.
// - Bit 5 enables input hysteresis; reset zero.
// - Pin two function select bits 3:0, codes 0 to 7; reset 0.
// - Pin three function select bits 3:0, codes 0 to 9; reset 1; codes 10 to 15 are also stored.
// - Pin three bit 4 routes the pin to converter channel nine.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module gpc_pin_pair (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// Register port
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdata,
	// Pad inputs
	input  wire        pin2In,
	input  wire        pin3In,
	// Pad controls, pin two
	output reg  [2:0]  pin2DriveStrength,
	output reg         pin2PullupStrongEn,
	output reg         pin2PulldownWeakEn,
	output reg         pin2PullupMidEn,
	output reg         pin2InputBufferEn,
	output reg         pin2OutputDriverEn,
	output reg         pin2HysteresisEn,
	output reg  [3:0]  pin2FunctionSelect,
	// Pad controls, pin three
	output reg  [2:0]  pin3DriveStrength,
	output reg         pin3PullupStrongEn,
	output reg         pin3PulldownWeakEn,
	output reg         pin3PullupWeakEn,
	output reg         pin3InputBufferEn,
	output reg         pin3OutputDriverEn,
	output reg         pin3HysteresisEn,
	output reg  [3:0]  pin3FunctionSelect,
	output reg         pin3AnalogSelect,
	// Gated pin levels to the core
	output reg         pin2CoreIn,
	output reg         pin3CoreIn,
	// Requests to the interrupt controller
	output reg  [1:0]  irqForward,
	output reg         irqOut
);
`include "gpc_regs.vh"

	////////////////////////////////////////////////////////////////////////////
	// Register write decode
	function isWrite;
		input [7:0] addr;
		input [7:0] off;
		input       wr;
		begin
			isWrite = wr && (addr == off);
		end
	endfunction

	reg  [31:0] ctl2_q;
	reg  [31:0] ctl3_q;
	reg  [1:0]  pend_q;
	reg  [1:0]  stat_q;
	reg  [1:0]  mask_q;
	wire [1:0]  pinLvl;
	wire [1:0]  hit;
	wire [1:0]  pendEn;
	wire [1:0]  fwdMask;
	wire [1:0]  inEn;
	wire [5:0]  trigSels;
	reg  [1:0]  event_d;
	reg  [31:0] rdata_d;
	reg  [1:0]  statClr_d;
	reg  [1:0]  statNext_d;

	////////////////////////////////////////////////////////////////////////////
	// Level that reaches the core: synced pin, buffer on, not in analog use
	function coreLevel;
		input level;
		input bufEn;
		input analog;
		begin
			coreLevel = level & bufEn & ~analog;
		end
	endfunction

	assign pendEn   = {ctl3_q[`GPC_B_PEND_EN], ctl2_q[`GPC_B_PEND_EN]};
	assign fwdMask  = {ctl3_q[`GPC_B_FWD_MASK], ctl2_q[`GPC_B_FWD_MASK]};
	assign inEn     = {ctl3_q[`GPC_B_IN_EN], ctl2_q[`GPC_B_IN_EN]};
	assign trigSels = {ctl3_q[`GPC_B_TRIG_HI:`GPC_B_TRIG_LO],
		ctl2_q[`GPC_B_TRIG_HI:`GPC_B_TRIG_LO]};

	////////////////////////////////////////////////////////////////////////////
	// Control registers; only documented bits are writable
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ctl2_q <= `GPC_RST_PIN2;
			ctl3_q <= `GPC_RST_PIN3;
		end else begin
			if (isWrite(regAddr, `GPC_OFF_PIN2, regWr)) begin
				// Function codes above 7 do not fit pin two, top bit held zero
				ctl2_q <= regWdata & (`GPC_WMASK_PIN2 | `GPC_FSEL_MASK2);
			end
			if (isWrite(regAddr, `GPC_OFF_PIN3, regWr)) begin
				ctl3_q <= regWdata & `GPC_WMASK_PIN3;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger detectors, one per pin
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : gTrig
			gpc_trigger_detect uDet (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.pinIn    (gi == 0 ? pin2In : pin3In),
				.trigSel  (trigSels[3*gi+2:3*gi]),
				.pinLevel (pinLvl[gi]),
				.trigHit  (hit[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pending events, gated by the pending enable
	always @* begin
		event_d = hit & pendEn;
	end

	// Write-one-to-clear strobe on the status offset
	always @* begin
		statClr_d = 2'b00;
		if (isWrite(regAddr, `GPC_OFF_IRQ_STAT, regWr)) begin
			statClr_d = regWdata[1:0];
		end
	end

	// Status after this edge; a new event beats a clear in the same cycle
	always @* begin
		statNext_d = (stat_q & ~statClr_d) | event_d;
	end

	// Pending flag per pin, registered from the event: one cycle per edge, held while a level trigger holds
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pend_q <= 2'b00;
		end else begin
			pend_q <= event_d;
		end
	end

	// Forward request only for enabled and unmasked triggers
	always @(posedge core_clk) begin
		if (!rst_n) begin
			irqForward <= 2'b00;
		end else begin
			irqForward <= event_d & fwdMask;
		end
	end

	// Sticky status bits
	always @(posedge core_clk) begin
		if (!rst_n) begin
			stat_q <= 2'b00;
		end else begin
			stat_q <= statNext_d;
		end
	end

	// Interrupt mask, same layout as the status
	always @(posedge core_clk) begin
		if (!rst_n) begin
			mask_q <= 2'b00;
		end else if (isWrite(regAddr, `GPC_OFF_IRQ_MASK, regWr)) begin
			mask_q <= regWdata[1:0];
		end
	end

	// Level interrupt follows the status as it stands after this edge
	always @(posedge core_clk) begin
		if (!rst_n) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= |(statNext_d & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pad drive level, both pins
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin2DriveStrength <= 3'h1;
			pin3DriveStrength <= 3'h1;
		end else begin
			pin2DriveStrength <= ctl2_q[`GPC_B_DRV_HI:`GPC_B_DRV_LO];
			pin3DriveStrength <= ctl3_q[`GPC_B_DRV_HI:`GPC_B_DRV_LO];
		end
	end

	// Pull resistors, pin two
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin2PullupStrongEn <= 1'b0;
			pin2PulldownWeakEn <= 1'b0;
			pin2PullupMidEn    <= 1'b0;
		end else begin
			pin2PullupStrongEn <= ctl2_q[`GPC_B_PU_STRONG];
			pin2PulldownWeakEn <= ctl2_q[`GPC_B_PD_WEAK];
			pin2PullupMidEn    <= ctl2_q[`GPC_B_PU_ALT];
		end
	end

	// Pull resistors, pin three
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin3PullupStrongEn <= 1'b0;
			pin3PulldownWeakEn <= 1'b0;
			pin3PullupWeakEn   <= 1'b0;
		end else begin
			pin3PullupStrongEn <= ctl3_q[`GPC_B_PU_STRONG];
			pin3PulldownWeakEn <= ctl3_q[`GPC_B_PD_WEAK];
			pin3PullupWeakEn   <= ctl3_q[`GPC_B_PU_ALT];
		end
	end

	// Buffers and hysteresis, pin two
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin2InputBufferEn  <= 1'b0;
			pin2OutputDriverEn <= 1'b0;
			pin2HysteresisEn   <= 1'b0;
		end else begin
			pin2InputBufferEn  <= ctl2_q[`GPC_B_IN_EN];
			pin2OutputDriverEn <= ctl2_q[`GPC_B_OUT_EN];
			pin2HysteresisEn   <= ctl2_q[`GPC_B_HYST];
		end
	end

	// Buffers and hysteresis, pin three; no driving into the converter
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin3InputBufferEn  <= 1'b0;
			pin3OutputDriverEn <= 1'b0;
			pin3HysteresisEn   <= 1'b0;
		end else begin
			pin3InputBufferEn  <= ctl3_q[`GPC_B_IN_EN];
			pin3OutputDriverEn <= ctl3_q[`GPC_B_OUT_EN] & ~ctl3_q[`GPC_B_ANALOG];
			pin3HysteresisEn   <= ctl3_q[`GPC_B_HYST];
		end
	end

	// Function routing, both pins
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin2FunctionSelect <= 4'h0;
			pin3FunctionSelect <= 4'h1;
		end else begin
			pin2FunctionSelect <= ctl2_q[`GPC_B_FSEL_HI:`GPC_B_FSEL_LO];
			pin3FunctionSelect <= ctl3_q[`GPC_B_FSEL_HI:`GPC_B_FSEL_LO];
		end
	end

	// Analog converter routing, pin three only
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin3AnalogSelect <= 1'b0;
		end else begin
			pin3AnalogSelect <= ctl3_q[`GPC_B_ANALOG];
		end
	end

	// Level reaches the core only with the input buffer on
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin2CoreIn <= 1'b0;
			pin3CoreIn <= 1'b0;
		end else begin
			pin2CoreIn <= coreLevel(pinLvl[0], inEn[0], 1'b0);
			pin3CoreIn <= coreLevel(pinLvl[1], inEn[1], ctl3_q[`GPC_B_ANALOG]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always @* begin
		case (regAddr)
			`GPC_OFF_PIN2:      rdata_d = ctl2_q;
			`GPC_OFF_PIN3:      rdata_d = ctl3_q;
			`GPC_OFF_IRQ_STAT:  rdata_d = {28'h000_0000, pend_q, stat_q};
			`GPC_OFF_IRQ_MASK:  rdata_d = {30'h0000_0000, mask_q};
			`GPC_OFF_PIN_LEVEL: rdata_d = {30'h0000_0000, pinLvl};
			default:            rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data one cycle after the strobe, held zero otherwise
	always @(posedge core_clk) begin
		if (!rst_n) begin
			regRdata <= 32'h0000_0000;
		end else begin
			regRdata <= regRd ? rdata_d : 32'h0000_0000;
		end
	end
endmodule // gpc_pin_pair

/* File: test/gpc_pin_pair_assertions.sv */
// Port checker for the pin control pair
`timescale 1ns/1ps
module gpc_pin_pair_chk (
	// Clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// Register port and pads
	input wire [7:0]  regAddr,
	input wire [31:0] regWdata,
	input wire        regWr,
	input wire        regRd,
	input wire [31:0] regRdata,
	input wire        pin2In,
	input wire        pin3In,
	// Watched outputs
	input wire [2:0]  pin2DriveStrength,
	input wire        pin2PullupMidEn,
	input wire        pin3OutputDriverEn,
	input wire        pin3AnalogSelect,
	input wire [3:0]  pin3FunctionSelect,
	input wire [1:0]  irqForward
);
	reg  [31:0] sh2Q;
	reg  [31:0] sh3Q;
	wire        arm2 = sh2Q[25] & sh2Q[20];
	wire        arm3 = sh3Q[25] & sh3Q[20];
	wire        hi2  = arm2 && sh2Q[23:21] == 3'h3 && pin2In;
	wire [3:0]  wPad = {regWdata[14:12], regWdata[8]};
	// Shadow of the written control words
	always @(posedge core_clk) begin
		if (!rst_n) begin
			sh2Q <= 32'h0000_0000;
			sh3Q <= 32'h0000_0000;
		end else if (regWr) begin
			if (regAddr == 8'h14) sh2Q <= regWdata;
			if (regAddr == 8'h18) sh3Q <= regWdata;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
		else $error("read data not zero outside read slot");
	a_reset_values: assert property ($rose(rst_n) |->
		pin2DriveStrength == 3'h1 && pin3FunctionSelect == 4'h1)
		else $error("pad controls wrong after reset");
	a_rise_two: assert property ($rose(pin2In) && sh2Q[23:21] == 3'h0 && arm2 |-> ##3 irqForward[0])
		else $error("rising edge not forwarded");
	a_fall_three: assert property ($fell(pin3In) && sh3Q[23:21] == 3'h1 && arm3 |-> ##3 irqForward[1])
		else $error("falling edge not forwarded");
	a_level_high: assert property (hi2 [*4] |-> irqForward[0])
		else $error("high level not forwarded");
	a_fwd_armed: assert property (irqForward[0] |-> $past(arm2))
		else $error("request forwarded while masked or disabled");
	a_pend_off: assert property (!sh3Q[20] && !$past(sh3Q[20], 3) |-> !irqForward[1])
		else $error("request with pending disabled");
	a_pad_follow: assert property (regWr && regAddr == 8'h14 |->
		##2 {pin2DriveStrength, pin2PullupMidEn} == $past(wPad, 2))
		else $error("pad controls do not follow write");
	a_analog_no_drive: assert property (pin3AnalogSelect |-> !pin3OutputDriverEn)
		else $error("driver on during analog use");
endmodule // gpc_pin_pair_chk
bind gpc_pin_pair gpc_pin_pair_chk u_chk (.core_clk, .rst_n, .regAddr, .regWdata, .regWr,
	.regRd, .regRdata, .pin2In, .pin3In, .pin2DriveStrength, .pin2PullupMidEn,
	.pin3OutputDriverEn, .pin3AnalogSelect, .pin3FunctionSelect, .irqForward);

/* File: test/gpc_pad_model.sv */
// Pad drivers and interrupt controller request counter
`timescale 1ns/1ps
module gpc_pad_model (
	// Clock and bench commands
	input wire       core_clk,
	input wire [1:0] pinCmd,
	input wire       cntClr,
	// Pads and requests
	output reg       pin2In,
	output reg       pin3In,
	input wire [1:0] irqForward,
	// Request cycle counts
	output reg [7:0] fwdCnt0,
	output reg [7:0] fwdCnt1
);
	// Defined levels from time zero
	initial begin
		pin2In = 1'b0;
		pin3In = 1'b0;
		fwdCnt0 = 8'h00;
		fwdCnt1 = 8'h00;
	end
	// Pads follow commands, requests are counted per cycle
	always @(posedge core_clk) begin
		pin2In <= pinCmd[0];
		pin3In <= pinCmd[1];
		fwdCnt0 <= cntClr ? 8'h00 : fwdCnt0 + {7'h00, irqForward[0]};
		fwdCnt1 <= cntClr ? 8'h00 : fwdCnt1 + {7'h00, irqForward[1]};
	end
endmodule // gpc_pad_model

/* File: test/test_gpc_pin_pair.sv */
// Self-checking bench for the pin control pair
`timescale 1ns/1ps
module test_gpc_pin_pair;
	reg         core_clk, rst_n, regWr, regRd, cntClr;
	reg  [7:0]  regAddr;
	reg  [31:0] regWdata;
	reg  [1:0]  pinCmd;
	wire [31:0] regRdata;
	wire        pin2In, pin3In, irqOut;
	wire [1:0]  irqForward, coreIn;
	wire [12:0] p2;
	wire [13:0] p3;
	wire [7:0]  cnt0, cnt1;
	integer     fails, totalChecks, p;
	gpc_pin_pair u_dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.pin2In(pin2In), .pin3In(pin3In), .pin2DriveStrength(p2[12:10]),
		.pin2PullupStrongEn(p2[9]), .pin2PulldownWeakEn(p2[8]), .pin2PullupMidEn(p2[7]),
		.pin2InputBufferEn(p2[6]), .pin2OutputDriverEn(p2[5]), .pin2HysteresisEn(p2[4]),
		.pin2FunctionSelect(p2[3:0]), .pin3DriveStrength(p3[13:11]),
		.pin3PullupStrongEn(p3[10]), .pin3PulldownWeakEn(p3[9]), .pin3PullupWeakEn(p3[8]),
		.pin3InputBufferEn(p3[7]), .pin3OutputDriverEn(p3[6]), .pin3HysteresisEn(p3[5]),
		.pin3AnalogSelect(p3[4]), .pin3FunctionSelect(p3[3:0]), .pin2CoreIn(coreIn[0]),
		.pin3CoreIn(coreIn[1]), .irqForward(irqForward), .irqOut(irqOut));
	gpc_pad_model u_pad (.core_clk(core_clk), .pinCmd(pinCmd), .cntClr(cntClr),
		.pin2In(pin2In), .pin3In(pin3In), .irqForward(irqForward), .fwdCnt0(cnt0),
		.fwdCnt1(cnt1));
	////////////////////////////////////////////////////////////////////////////////
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			totalChecks = totalChecks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge core_clk);
			#1;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'b1;
			@(posedge core_clk);
			regWr <= 1'b0;
		end
	endtask
	// Read data stands only in the cycle after the strobe
	task rd(input [7:0] a, input [31:0] exp);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regRd <= 1'b1;
			tick(1);
			regRd <= 1'b0;
			check("read", regRdata, exp);
		end
	endtask
	// One ten-cycle excursion from the idle level, then count requests
	task pulse(input q, input [31:0] cfg, input idle, input [7:0] exp);
		begin
			pinCmd[q] <= idle;
			wr(q ? 8'h18 : 8'h14, cfg);
			tick(6);
			cntClr <= 1'b1;
			tick(1);
			cntClr <= 1'b0;
			pinCmd[q] <= !idle;
			tick(10);
			pinCmd[q] <= idle;
			tick(8);
			check("requests", q ? cnt1 : cnt0, {24'h0, exp});
		end
	endtask
	task sReset;
		begin
			check("pads", {p3, p2}, {14'h0801, 13'h0400});
			rd(8'h14, 32'h0000_1000);
			rd(8'h18, 32'h0000_1001);
			rd(8'h30, 32'h0000_0000);
		end
	endtask
	task sRegs;
		begin
			wr(8'h14, 32'hFFFF_FFFF);
			rd(8'h14, 32'h02F0_7BE7);
			check("pin two pads", p2, 13'h1FF7);
			pinCmd[0] <= 1'b1;
			tick(5);
			check("pin two level", coreIn[0], 1'b1);
			wr(8'h14, 32'h0000_0000);
			tick(3);
			check("pin two off", {p2, coreIn[0]}, 14'h0000);
			pinCmd[0] <= 1'b0;
			wr(8'h18, 32'hFFFF_FFFF);
			rd(8'h18, 32'h02F0_7BFF);
			check("pin three pads", p3, 14'h3FBF);
			wr(8'h18, 32'h0000_0089);
			pinCmd[1] <= 1'b1;
			tick(5);
			check("pin three digital", {p3, coreIn[1]}, 15'h0113);
			// Converter channel nine only ever given to pin three
			wr(8'h18, 32'h0000_0090);
			tick(3);
			check("pin three analog", {p3, coreIn[1]}, 15'h0120);
			pinCmd[1] <= 1'b0;
		end
	endtask
	task sTrig;
		for (p = 0; p < 2; p = p + 1) begin
			pulse(p[0], 32'h0210_0080, 1'b0, 8'h01);
			pulse(p[0], 32'h0230_0080, 1'b0, 8'h01);
			pulse(p[0], 32'h0250_0080, 1'b0, 8'h02);
			pulse(p[0], 32'h0270_0080, 1'b0, 8'h0A);
			pulse(p[0], 32'h0290_0080, 1'b1, 8'h0A);
			pulse(p[0], 32'h02B0_0080, 1'b0, 8'h00);
		end
	endtask
	task sPend;
		begin
			wr(8'h40, 32'h0000_0003);
			pulse(1'b0, 32'h0010_0080, 1'b0, 8'h00);
			rd(8'h40, 32'h0000_0001);
			check("irq masked", irqOut, 1'b0);
			wr(8'h44, 32'h0000_0001);
			tick(2);
			check("irq set", irqOut, 1'b1);
			wr(8'h40, 32'h0000_0001);
			tick(2);
			check("irq cleared", irqOut, 1'b0);
			pulse(1'b0, 32'h0200_0080, 1'b0, 8'h00);
			rd(8'h40, 32'h0000_0000);
		end
	endtask
	task printVerdict;
		begin
			if (fails == 0 && totalChecks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Clock, reset, sequence and watchdog
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		{rst_n, regWr, regRd, cntClr, regAddr, regWdata, pinCmd} = 0;
		fails = 0;
		totalChecks = 0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		sReset;
		sRegs;
		sTrig;
		sPend;
		printVerdict;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		fails = fails + 1;
		printVerdict;
	end
endmodule // test_gpc_pin_pair
